//--- hw/cil_pkg.sv
/*
 Constants, types and register map of the cutter input command logic.
 Assumes one 200 MHz clock, APB access to the registers and a host-side motion core.
*/
package cil_pkg;

    // ==========================================================
    // Sizes and command positions
    localparam int NCMD    = 10;
    localparam int NPIN    = 6;
    localparam int SELW    = 4;
    localparam int C_START = 0;
    localparam int C_FWD   = 1;
    localparam int C_REV   = 2;
    localparam int C_HOME  = 3;
    localparam int C_SELVM = 4;
    localparam int C_RUNVM = 5;
    localparam int C_CLR   = 6;
    localparam int C_TEST  = 7;
    localparam int C_TEACH = 8;
    localparam int C_THICK = 9;

    // ==========================================================
    // Register byte offsets
    localparam logic [7:0] A_SW_CMD   = 8'h00;
    localparam logic [7:0] A_MAP0     = 8'h04;
    localparam logic [7:0] A_MAP1     = 8'h08;
    localparam logic [7:0] A_JOG      = 8'h0C;
    localparam logic [7:0] A_TRIM     = 8'h10;
    localparam logic [7:0] A_VMSPD    = 8'h14;
    localparam logic [7:0] A_RAMP     = 8'h18;
    localparam logic [7:0] A_CUT_LEN  = 8'h1C;
    localparam logic [7:0] A_TEST_LEN = 8'h20;
    localparam logic [7:0] A_STATUS   = 8'h24;
    localparam logic [7:0] A_ERR      = 8'h28;
    localparam logic [7:0] A_PM_SET   = 8'h2C;
    localparam logic [7:0] A_VM_FREQ  = 8'h30;

    // ==========================================================
    // Values after reset
    localparam logic [31:0] MAP0_RST  = 32'h0000_6542;
    localparam logic [31:0] MAP1_RST  = 32'h0000_0000;
    localparam logic [15:0] JOG_RST   = 16'h0100;
    localparam logic [15:0] TRIM_RST  = 16'h0010;
    localparam logic [23:0] VMSPD_RST = 24'h00_1000;
    localparam logic [23:0] RAMP_RST  = 24'h00_0001;
    localparam logic [31:0] CUT_RST   = 32'h0000_1000;
    localparam logic [31:0] TEST_RST  = 32'h0000_0800;

    typedef enum logic [2:0] {M_HOLD, M_JOG, M_AUTO, M_SEEK, M_HOME} cil_mode_t;

endpackage

//--- hw/cil_ramp_if.sv
/*
 Carrier between the command decoder and the virtual master generator.
 Assumes both ends share the system clock.
*/
`timescale 1ns/1ps
`default_nettype none
interface cil_ramp_if;
    logic        run;
    logic [23:0] target;
    logic [23:0] step;
    logic [23:0] freq;
    modport ctl (output run, output target, output step, input freq);
    modport gen (input run, input target, input step, output freq);
endinterface
`default_nettype wire

//--- hw/cil_sync.sv
/*
 Input synchroniser and edge finder for the command sources.
 Assumes pins may be asynchronous; the combined command vector is synchronous.
*/
`timescale 1ns/1ps
`default_nettype none
module cil_sync
    import cil_pkg::*;
(
    input  wire logic            clk_i,
    input  wire logic            rst_n_i,
    input  wire logic            ce_i,
    input  wire logic [NPIN-1:0] pins_i,
    input  wire logic [NCMD-1:0] cmd_i,
    output logic      [NPIN-1:0] pins_o,
    output logic      [NCMD-1:0] lvl_o,
    output logic      [NCMD-1:0] rise_o,
    output logic      [NCMD-1:0] fall_o
);
    typedef struct packed {
        logic [NPIN-1:0] s1;
        logic [NPIN-1:0] s2;
        logic [NCMD-1:0] lvl;
        logic [NCMD-1:0] rise;
        logic [NCMD-1:0] fall;
    } cil_sync_st_t;

    cil_sync_st_t st;
    cil_sync_st_t next_st;

    // ==========================================================
    // Two stages, then one registered level with its edges.
    always_comb
    begin
        next_st = st;
        if (ce_i)
        begin
            next_st.s1   = pins_i;
            next_st.s2   = st.s1;
            next_st.lvl  = cmd_i;
            next_st.rise = cmd_i & ~st.lvl;
            next_st.fall = ~cmd_i & st.lvl;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
            st <= '0;
        else
            st <= next_st;
    end

    assign pins_o = st.s2;
    assign lvl_o  = st.lvl;
    assign rise_o = st.rise;
    assign fall_o = st.fall;

    a_edge_single : assert property (@(posedge clk_i) disable iff (!rst_n_i)
        ce_i && (st.rise != '0) |=> ((st.rise & $past(st.rise)) == '0))
        else $error("rise pulse lasted two cycles");
endmodule
`default_nettype wire

//--- hw/cil_ramp.sv
/*
 Virtual master frequency generator with a linear ramp.
 Assumes step is the frequency change per clock cycle.
*/
`timescale 1ns/1ps
`default_nettype none
module cil_ramp
    import cil_pkg::*;
(
    input  wire logic clk_i,
    input  wire logic rst_n_i,
    input  wire logic ce_i,
    cil_ramp_if.gen   rif
);
    typedef struct packed {
        logic [23:0] freq;
    } cil_ramp_st_t;

    cil_ramp_st_t st;
    cil_ramp_st_t next_st;
    logic [23:0]  goal;
    logic [23:0]  gap;

    // ==========================================================
    // Steps toward the goal and never overshoots it.
    always_comb
    begin
        next_st = st;
        goal    = rif.run ? rif.target : 24'h00_0000;
        gap     = (st.freq < goal) ? goal - st.freq : st.freq - goal;
        if (ce_i)
        begin
            if (st.freq < goal)
                next_st.freq = st.freq + ((gap < rif.step) ? gap : rif.step);
            else if (st.freq > goal)
                next_st.freq = st.freq - ((gap < rif.step) ? gap : rif.step);
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
            st <= '0;
        else
            st <= next_st;
    end

    assign rif.freq = st.freq;
endmodule
`default_nettype wire

//--- hw/cil_top.sv
/*
 Command decoder of a rotary cutter: roll motion mode, master choice,
 virtual master run, errors, cut length, print mark teach and thickness.
 Assumes positions and pulses from the motion core are synchronous.
*/
// Our own choices: the register offsets and the APB register port.
`timescale 1ns/1ps
`default_nettype none
module cil_top
    import cil_pkg::*;
(
    input  wire logic            CLK_SYS_I,
    input  wire logic            RESETN_I,
    input  wire logic            CE_I,
    input  wire logic            PSEL_I,
    input  wire logic            PENABLE_I,
    input  wire logic            PWRITE_I,
    input  wire logic [7:0]      PADDR_I,
    input  wire logic [31:0]     PWDATA_I,
    output logic      [31:0]     PRDATA_O,
    output logic                 PREADY_O,
    output logic                 PSLVERR_O,
    input  wire logic [1:0]      FAST_IN_I,
    input  wire logic [3:0]      CTRL_IN_I,
    input  wire logic [NCMD-1:0] FIELDBUS_CMD_I,
    input  wire logic [31:0]     POS_I,
    input  wire logic [31:0]     LINE_POS_I,
    input  wire logic            CUT_PULSE_I,
    input  wire logic            AT_HOME_I,
    input  wire logic            MARK_I,
    input  wire logic            CYCLE_I,
    input  wire logic [7:0]      ERR_EVT_I,
    output logic      [2:0]      ROLL_MODE_O,
    output logic      [15:0]     ROLL_SPEED_O,
    output logic      [31:0]     HOLD_POS_O,
    output logic                 MASTER_VIRT_O,
    output logic      [23:0]     VM_FREQ_O,
    output logic      [31:0]     CUT_LEN_O,
    output logic      [7:0]      ERR_O,
    output logic      [31:0]     PM_SET_O,
    output logic                 THICK_O
);
    typedef struct packed {
        logic [NCMD-1:0] sw_cmd;
        logic [31:0]     map0;
        logic [31:0]     map1;
        logic [15:0]     jog;
        logic [15:0]     trim;
        logic [23:0]     vmspd;
        logic [23:0]     ramp;
        logic [31:0]     cut_len;
        logic [31:0]     test_len;
        cil_mode_t       mode;
        logic [15:0]     speed;
        logic [31:0]     hold_pos;
        logic            master_virt;
        logic [31:0]     act_len;
        logic            test_pend;
        logic [7:0]      err;
        logic [31:0]     pm_set;
        logic            pm_seen;
        logic            thick;
        logic [31:0]     prdata;
        logic            pready;
        logic            pslverr;
    } cil_top_st_t;

    cil_top_st_t     st;
    cil_top_st_t     next_st;
    logic [NPIN-1:0] pins;
    logic [NCMD-1:0] hw_cmd;
    logic [NCMD-1:0] cmd;
    logic [NCMD-1:0] lvl;
    logic [NCMD-1:0] rise;
    logic [NCMD-1:0] fall;
    logic [63:0]     map_all;
    logic [15:0]     pin_tab;
    logic [31:0]     rd_data;
    logic            rd_hit;
    logic            setup;
    logic            wr;
    logic            jog_one;

    cil_ramp_if rif ();

    // ==========================================================
    // Sources, mapping and synchronisation
    // Selector 0 means unassigned; 1..2 fast inputs, 3..6 control inputs.
    assign pin_tab = {{(15 - NPIN){1'b0}}, pins, 1'b0};
    assign map_all = {st.map1, st.map0};

    for (genvar g = 0; g < NCMD; g++)
    begin : g_map
        assign hw_cmd[g] = pin_tab[map_all[g*SELW +: SELW]];
    end

    assign cmd = hw_cmd | st.sw_cmd | FIELDBUS_CMD_I;

    cil_sync cil_sync_inst (
        .clk_i   (CLK_SYS_I),
        .rst_n_i (RESETN_I),
        .ce_i    (CE_I),
        .pins_i  ({CTRL_IN_I, FAST_IN_I}),
        .cmd_i   (cmd),
        .pins_o  (pins),
        .lvl_o   (lvl),
        .rise_o  (rise),
        .fall_o  (fall)
    );

    assign rif.run    = lvl[C_RUNVM];
    assign rif.target = st.vmspd;
    assign rif.step   = st.ramp;

    cil_ramp cil_ramp_inst (
        .clk_i   (CLK_SYS_I),
        .rst_n_i (RESETN_I),
        .ce_i    (CE_I),
        .rif     (rif)
    );

    // ==========================================================
    // Register read mux
    always_comb
    begin
        rd_hit  = 1'b1;
        rd_data = 32'h0000_0000;
        case (PADDR_I)
            A_SW_CMD:   rd_data = {{(32 - NCMD){1'b0}}, st.sw_cmd};
            A_MAP0:     rd_data = st.map0;
            A_MAP1:     rd_data = st.map1;
            A_JOG:      rd_data = {16'h0000, st.jog};
            A_TRIM:     rd_data = {16'h0000, st.trim};
            A_VMSPD:    rd_data = {8'h00, st.vmspd};
            A_RAMP:     rd_data = {8'h00, st.ramp};
            A_CUT_LEN:  rd_data = st.cut_len;
            A_TEST_LEN: rd_data = st.test_len;
            A_STATUS:   rd_data = {24'h00_0000, st.thick, st.master_virt, st.test_pend, st.pm_seen,
                                   1'b0, st.mode};
            A_ERR:      rd_data = {24'h00_0000, st.err};
            A_PM_SET:   rd_data = st.pm_set;
            A_VM_FREQ:  rd_data = {8'h00, rif.freq};
            default:    rd_hit = 1'b0;
        endcase
    end

    assign setup   = PSEL_I & ~PENABLE_I;
    assign wr      = PSEL_I & PENABLE_I & PWRITE_I & st.pready;
    assign jog_one = lvl[C_FWD] ^ lvl[C_REV];

    // ==========================================================
    // Next state
    // Read data is taken in the setup phase so that PRDATA_O is a flop;
    // the price is one fixed wait-free access with data one phase early.
    always_comb
    begin
        next_st         = st;
        next_st.pready  = setup;
        next_st.pslverr = setup & ~rd_hit;
        if (setup)
            next_st.prdata = rd_data;
        if (wr)
        begin
            case (PADDR_I)
                A_SW_CMD:   next_st.sw_cmd = PWDATA_I[NCMD-1:0];
                A_MAP0:     next_st.map0 = PWDATA_I;
                A_MAP1:     next_st.map1 = PWDATA_I;
                A_JOG:      next_st.jog = PWDATA_I[15:0];
                A_TRIM:     next_st.trim = PWDATA_I[15:0];
                A_VMSPD:    next_st.vmspd = PWDATA_I[23:0];
                A_RAMP:     next_st.ramp = PWDATA_I[23:0];
                A_CUT_LEN:  next_st.cut_len = PWDATA_I;
                A_TEST_LEN: next_st.test_len = PWDATA_I;
                default:    next_st.sw_cmd = st.sw_cmd;
            endcase
        end
        if (CE_I)
        begin
            // Start wins over homing and jogging; it also aborts a homing run.
            if (lvl[C_START])
            begin
                next_st.mode  = M_AUTO;
                next_st.speed = !jog_one ? 16'h0000 :
                                lvl[C_FWD] ? st.trim : 16'(-st.trim);
            end
            else if (st.mode == M_SEEK)
            begin
                next_st.speed = st.jog;
                if (CUT_PULSE_I)
                    next_st.mode = M_HOME;
            end
            else if (st.mode == M_HOME)
            begin
                if (AT_HOME_I)
                begin
                    next_st.mode     = M_HOLD;
                    next_st.speed    = 16'h0000;
                    next_st.hold_pos = POS_I;
                end
            end
            else if (rise[C_HOME])
            begin
                next_st.mode  = M_SEEK;
                next_st.speed = st.jog;
            end
            else if (jog_one)
            begin
                next_st.mode  = M_JOG;
                next_st.speed = lvl[C_FWD] ? st.jog : 16'(-st.jog);
            end
            else
            begin
                if (st.mode != M_HOLD)
                    next_st.hold_pos = POS_I;
                next_st.mode  = M_HOLD;
                next_st.speed = 16'h0000;
            end

            if (!lvl[C_START])
                next_st.master_virt = lvl[C_SELVM];

            // A new error in the clearing cycle survives the clear.
            next_st.err = (rise[C_CLR] ? 8'h00 : st.err) | ERR_EVT_I;

            if (CYCLE_I)
                next_st.act_len = (lvl[C_TEST] | st.test_pend) ? st.test_len : st.cut_len;
            next_st.test_pend = (st.test_pend | rise[C_TEST]) & ~CYCLE_I;

            if (rise[C_TEACH])
                next_st.pm_seen = 1'b0;
            if (lvl[C_TEACH] && MARK_I)
            begin
                next_st.pm_seen = 1'b1;
                next_st.pm_set  = LINE_POS_I;
            end
            if (fall[C_TEACH] && !st.pm_seen)
                next_st.pm_set = LINE_POS_I;

            next_st.thick = lvl[C_THICK];
        end
    end

    always_ff @(posedge CLK_SYS_I)
    begin
        if (!RESETN_I)
        begin
            st          <= '0;
            st.map0     <= MAP0_RST;
            st.map1     <= MAP1_RST;
            st.jog      <= JOG_RST;
            st.trim     <= TRIM_RST;
            st.vmspd    <= VMSPD_RST;
            st.ramp     <= RAMP_RST;
            st.cut_len  <= CUT_RST;
            st.test_len <= TEST_RST;
            st.act_len  <= CUT_RST;
            st.mode     <= M_HOLD;
        end
        else
            st <= next_st;
    end

    assign PRDATA_O      = st.prdata;
    assign PREADY_O      = st.pready;
    assign PSLVERR_O     = st.pslverr;
    assign ROLL_MODE_O   = st.mode;
    assign ROLL_SPEED_O  = st.speed;
    assign HOLD_POS_O    = st.hold_pos;
    assign MASTER_VIRT_O = st.master_virt;
    assign VM_FREQ_O     = rif.freq;
    assign CUT_LEN_O     = st.act_len;
    assign ERR_O         = st.err;
    assign PM_SET_O      = st.pm_set;
    assign THICK_O       = st.thick;

    // ==========================================================
    // Checks
    default clocking cb @(posedge CLK_SYS_I); endclocking
    default disable iff (!RESETN_I);

    a_jog_speed : assert property (
        CE_I && !wr && !lvl[C_START] && st.mode inside {M_HOLD, M_JOG} && !rise[C_HOME] && lvl[C_REV]
        && !lvl[C_FWD] |=> ROLL_MODE_O == M_JOG && ROLL_SPEED_O == 16'(-$past(st.jog)))
        else $error("reverse jog speed wrong");
    a_jog_hold : assert property (
        CE_I && st.mode == M_JOG && !lvl[C_START] && !jog_one && !rise[C_HOME]
        |=> ROLL_MODE_O == M_HOLD && HOLD_POS_O == $past(POS_I) && ROLL_SPEED_O == 16'h0000)
        else $error("jog end did not hold position");
    a_trim_fwd : assert property (
        CE_I && !wr && lvl[C_START] && lvl[C_FWD] && !lvl[C_REV] |=> ROLL_SPEED_O == $past(st.trim))
        else $error("trim speed wrong");
    a_home_seq : assert property (
        CE_I && st.mode == M_SEEK && !lvl[C_START] && CUT_PULSE_I ##1 CE_I && !lvl[C_START] && !AT_HOME_I
        |=> ROLL_MODE_O == M_HOME)
        else $error("homing did not pass to home run");
    a_master_take : assert property (
        CE_I && !lvl[C_START] |=> MASTER_VIRT_O == $past(lvl[C_SELVM]))
        else $error("master select not taken");
    a_master_keep : assert property (
        lvl[C_START] |=> $stable(MASTER_VIRT_O))
        else $error("master changed while running");
    a_ramp_down : assert property (
        CE_I && !rif.run && rif.freq != 24'h00_0000 && rif.step != 24'h00_0000 |=> rif.freq < $past(rif.freq))
        else $error("generator not ramping down");
    a_ramp_up : assert property (
        CE_I && rif.run && rif.freq < rif.target && rif.step != 24'h00_0000 |=> rif.freq > $past(rif.freq))
        else $error("generator not ramping up");
    a_err_clear : assert property (
        CE_I && rise[C_CLR] && ERR_EVT_I == 8'h00 |=> ERR_O == 8'h00)
        else $error("errors not cleared");
    a_len_select : assert property (
        CE_I && CYCLE_I && lvl[C_TEST] |=> CUT_LEN_O == $past(st.test_len))
        else $error("test length not applied");
    a_test_once : assert property (
        CE_I && CYCLE_I && !rise[C_TEST] |=> !st.test_pend)
        else $error("single test cut repeated");
    a_teach_mark : assert property (
        CE_I && lvl[C_TEACH] && MARK_I |=> PM_SET_O == $past(LINE_POS_I) && st.pm_seen)
        else $error("taught mark not taken");
    a_teach_fall : assert property (
        CE_I && fall[C_TEACH] && !st.pm_seen |=> PM_SET_O == $past(LINE_POS_I))
        else $error("falling edge set point not taken");
    a_thick_sel : assert property (
        CE_I |=> THICK_O == $past(lvl[C_THICK]))
        else $error("material thickness not applied");
    a_src_or : assert property (
        CE_I && FIELDBUS_CMD_I[C_START] ##1 CE_I |-> lvl[C_START] ##1 ROLL_MODE_O == M_AUTO)
        else $error("fieldbus start not seen");
    c_home_done : cover property (st.mode == M_HOME ##1 st.mode == M_HOLD);
    c_trim_auto : cover property (st.mode == M_AUTO && st.speed != 16'h0000);
    c_teach_fall : cover property (fall[C_TEACH] && !st.pm_seen);
    c_test_pulse : cover property (st.test_pend && CYCLE_I && !lvl[C_TEST]);
endmodule
`default_nettype wire

//--- dv/cil_core_model.sv
/*
 Motion core model on the far side of the cutter command logic.
 Assumes the roll follows the speed command each clock and that the sensors give clean pulses.
*/
`timescale 1ns/1ps
`default_nettype none
module cil_core_model
(
    input  wire logic        clk_i,
    input  wire logic        rst_n_i,
    input  wire logic [2:0]  mode_i,
    input  wire logic [15:0] speed_i,
    output logic      [31:0] pos_o,
    output logic             index_o,
    output logic             home_o,
    output logic             cycle_o
);
    // ==========================================================
    // Roll position and sensors
    logic [5:0] cnt;

    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            pos_o   <= 32'h0;
            cnt     <= 6'h0;
            index_o <= 1'b0;
            home_o  <= 1'b0;
            cycle_o <= 1'b0;
        end
        else
        begin
            // The position integrates speed, so a held roll stays where it is.
            pos_o   <= pos_o + {{16{speed_i[15]}}, speed_i};
            cnt     <= cnt + 6'h1;
            index_o <= (mode_i == 3'h3) && (cnt[3:0] == 4'hF);
            home_o  <= (mode_i == 3'h4) && (cnt[3:0] == 4'h7);
            cycle_o <= (cnt == 6'h3F);
        end
    end
endmodule
`default_nettype wire

//--- dv/cutter_input_command_logic_test.sv
/*
 Self-checking bench of the cutter command decoder.
 Assumes the core model supplies position, index, home and cycle signals.
*/
`timescale 1ns/1ps
`default_nettype none
module cutter_input_command_logic_test
    import cil_pkg::*;
;
    logic clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]  paddr = 8'h0, err_evt = 8'h0;
    logic [31:0] pwdata = 32'h0, line = 32'h0, rd, prdata, pos, hold_pos, cut_len, pm_set;
    logic [1:0]  fast = 2'h0;
    logic [3:0]  ctrl = 4'h0;
    logic [9:0]  fb = 10'h0;
    logic        mark = 1'b0, ce = 1'b1, er, pready, pslverr, index, home, cycle, virt, thick;
    logic [2:0]  mode;
    logic [15:0] speed;
    logic [23:0] freq;
    logic [7:0]  err;
    int          error_cnt = 0, checks = 0;
    logic [31:0] rv [9] = '{32'h0, MAP0_RST, MAP1_RST, 32'(JOG_RST), 32'(TRIM_RST),
                            32'(VMSPD_RST), 32'(RAMP_RST), CUT_RST, TEST_RST};

    always #2.5 clk = ~clk;

    cil_top cil_top_inst (.CLK_SYS_I(clk), .RESETN_I(rst_n), .CE_I(ce), .PSEL_I(psel),
        .PENABLE_I(penable), .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
        .PREADY_O(pready), .PSLVERR_O(pslverr), .FAST_IN_I(fast), .CTRL_IN_I(ctrl), .FIELDBUS_CMD_I(fb),
        .POS_I(pos), .LINE_POS_I(line), .CUT_PULSE_I(index), .AT_HOME_I(home), .MARK_I(mark),
        .CYCLE_I(cycle), .ERR_EVT_I(err_evt), .ROLL_MODE_O(mode), .ROLL_SPEED_O(speed),
        .HOLD_POS_O(hold_pos), .MASTER_VIRT_O(virt), .VM_FREQ_O(freq), .CUT_LEN_O(cut_len),
        .ERR_O(err), .PM_SET_O(pm_set), .THICK_O(thick));

    cil_core_model cil_core_model_inst (.clk_i(clk), .rst_n_i(rst_n), .mode_i(mode), .speed_i(speed),
        .pos_o(pos), .index_o(index), .home_o(home), .cycle_o(cycle));

    // ==========================================================
    // Shared tasks
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // One APB transfer; an idle cycle follows so no signal is set twice in a time step.
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        for (int n = 0; n < 20; n++)
        begin
            @(posedge clk);
            if (pready === 1'b1)
                break;
        end
        chk(32'(pready), 32'h1);
        if (pready !== 1'b1)
            close_out();
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask

    task automatic wait_cyc();
        for (int n = 0; n < 100 && cycle !== 1'b1; n++)
            @(posedge clk);
        chk(32'(cycle), 32'h1);
        tick(2);
    endtask

    task automatic close_out();
        $display("checks=%0d error_cnt=%0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // ==========================================================
    // Tests
    initial
    begin
        tick(2);
        rst_n <= 1'b1;
        tick(1);
        for (int i = 0; i < 9; i++)
        begin
            apb(1'b0, 8'(4 * i), 32'h0);
            chk(rd, rv[i]);
        end
        apb(1'b0, 8'h40, 32'h0);
        chk({rd[30:0], er}, 32'h1);
        apb(1'b1, A_STATUS, 32'hFFFF_FFFF);
        apb(1'b0, A_STATUS, 32'h0);
        chk(rd, 32'h0);
        $display("test registers done");
        ctrl <= 4'h2;
        tick(5);
        chk(32'(mode), 32'h1);
        chk(32'(speed), 32'(JOG_RST));
        ctrl <= 4'h0;
        tick(5);
        chk(32'(mode), 32'h0);
        // The roll still runs one cycle at jog speed while the stop is registered.
        chk(hold_pos + 32'(JOG_RST), pos);
        fb <= 10'h004;
        tick(3);
        chk(32'(speed), 32'h0000_FF00);
        fb <= 10'h000;
        fast <= 2'h2;
        tick(5);
        chk(32'(mode), 32'h2);
        fb <= 10'h002;
        tick(3);
        chk(32'(speed), 32'(TRIM_RST));
        fb <= 10'h010;
        tick(3);
        chk(32'(virt), 32'h0);
        fast <= 2'h0;
        tick(5);
        chk({28'h0, virt, mode}, 32'h8);
        fb <= 10'h000;
        tick(3);
        chk(32'(virt), 32'h0);
        $display("test jog trim master done");
        ctrl <= 4'h8;
        tick(6);
        ctrl <= 4'h0;
        for (int n = 0; n < 10 && mode !== 3'h3; n++)
            tick(1);
        chk(32'(mode), 32'h3);
        for (int n = 0; n < 40 && mode !== 3'h4; n++)
            tick(1);
        chk(32'(mode), 32'h4);
        for (int n = 0; n < 40 && mode !== 3'h0; n++)
            tick(1);
        chk(32'(mode), 32'h0);
        $display("test homing done");
        ce <= 1'b0;
        fb <= 10'h001;
        tick(4);
        chk(32'(mode), 32'h0);
        ce <= 1'b1;
        tick(3);
        chk(32'(mode), 32'h2);
        fb <= 10'h000;
        tick(3);
        chk(32'(mode), 32'h0);
        $display("test clock enable done");
        apb(1'b1, A_RAMP, 32'h100);
        fb <= 10'h020;
        for (int n = 0; n < 100 && freq !== 24'h001000; n++)
            tick(1);
        chk(32'(freq), 32'(VMSPD_RST));
        apb(1'b0, A_VM_FREQ, 32'h0);
        chk(rd, 32'(VMSPD_RST));
        fb <= 10'h000;
        for (int n = 0; n < 100 && freq !== 24'h0; n++)
            tick(1);
        chk(32'(freq), 32'h0);
        tick(5);
        chk(32'(freq), 32'h0);
        $display("test ramp done");
        err_evt <= 8'h04;
        tick(1);
        err_evt <= 8'h00;
        apb(1'b0, A_ERR, 32'h0);
        chk(rd, 32'h4);
        apb(1'b1, A_SW_CMD, 32'h40);
        apb(1'b1, A_SW_CMD, 32'h200);
        tick(2);
        chk({23'h0, thick, err}, 32'h100);
        fb <= 10'h200;
        apb(1'b1, A_SW_CMD, 32'h0);
        tick(3);
        chk(32'(thick), 32'h1);
        fb <= 10'h000;
        tick(3);
        chk(32'(thick), 32'h0);
        $display("test error thickness done");
        fb <= 10'h080;
        tick(3);
        wait_cyc();
        chk(cut_len, TEST_RST);
        fb <= 10'h000;
        wait_cyc();
        chk(cut_len, CUT_RST);
        fb <= 10'h080;
        tick(1);
        fb <= 10'h000;
        wait_cyc();
        chk(cut_len, TEST_RST);
        wait_cyc();
        chk(cut_len, CUT_RST);
        $display("test cut length done");
        apb(1'b1, A_MAP1, 32'h1);
        apb(1'b0, A_MAP1, 32'h0);
        chk(rd, 32'h1);
        line <= 32'h1234;
        fast <= 2'h1;
        tick(6);
        fast <= 2'h0;
        tick(6);
        chk(pm_set, 32'h1234);
        line <= 32'h5678;
        fast <= 2'h1;
        tick(6);
        mark <= 1'b1;
        tick(1);
        mark <= 1'b0;
        tick(2);
        line <= 32'h9ABC;
        fast <= 2'h0;
        tick(6);
        chk(pm_set, 32'h5678);
        apb(1'b0, A_PM_SET, 32'h0);
        chk(rd, 32'h5678);
        $display("test teach done");
        close_out();
    end
endmodule
`default_nettype wire
